// ---- hdl/dbj_pkg.sv ----
// Constants, types and settings for the brake, jog and up-down frequency sequencer.
// Assumes a single 250 MHz clock and parameters written over APB.
package dbj_pkg;
	localparam int unsigned CLK_HZ         = 250_000_000;
	// Frequencies in 0.01 Hz, times in 0.1 s, current in 0.1 A
	localparam logic [15:0] BRAKE_START_FREQ_RST = 16'h01F4;
	localparam logic [15:0] BRAKE_WAIT_TIME_RST  = 16'h0001;
	localparam logic [7:0]  BRAKE_LEVEL_RST      = 8'h32;
	localparam logic [15:0] BRAKE_DURATION_RST   = 16'h000A;
	localparam logic [7:0]  START_BRAKE_LVL_RST  = 8'h32;
	localparam logic [15:0] START_BRAKE_DUR_RST  = 16'h0000;
	localparam logic [15:0] JOG_FREQ_RST         = 16'h03E8;
	localparam logic [15:0] MAX_FREQ_RST         = 16'h1770;
	localparam logic [15:0] START_FREQ_RST       = 16'h0032;
	localparam logic [15:0] MOTOR_CURRENT_RST    = 16'h0107;
	localparam logic [15:0] MOTOR_CURRENT_MIN    = 16'h0005;
	localparam logic [15:0] MOTOR_CURRENT_MAX    = 16'h01F4;
	localparam logic [7:0]  LEVEL_MAX            = 8'hC8;
	localparam logic [1:0]  STOP_MODE_BRAKE      = 2'h1;
	localparam logic [3:0]  FREQ_METHOD_UPDOWN   = 4'h8;
	// Input function codes
	localparam logic [4:0]  FN_JOG       = 5'h04;
	localparam logic [4:0]  FN_DC_BRAKE  = 5'h0B;
	localparam logic [4:0]  FN_UP        = 5'h0F;
	localparam logic [4:0]  FN_DOWN      = 5'h10;
	localparam logic [4:0]  FN_UD_CLEAR  = 5'h19;
	localparam logic [4:0]  FN_JOG_FWD   = 5'h1A;
	localparam logic [4:0]  FN_JOG_REV   = 5'h1B;
	// Timing: 0.1 s tick, 10 ms debounce, 3 s hold
	localparam int unsigned TICK_MS       = 100;
	localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned DEBOUNCE_MS   = 10;
	localparam int unsigned DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int unsigned HOLD_S        = 3;
	localparam logic [5:0]  HOLD_TICKS    = 6'(HOLD_S * 1000 / TICK_MS);
	localparam logic [15:0] RAMP_STEP     = 16'h0001;
	localparam int unsigned RAMP_CYC_DEF  = 25_000;
	// APB register offsets
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_BRAKE_FREQ = 8'h04;
	localparam logic [7:0] REG_BRAKE_WAIT = 8'h08;
	localparam logic [7:0] REG_BRAKE_DUR  = 8'h0C;
	localparam logic [7:0] REG_START_DUR  = 8'h10;
	localparam logic [7:0] REG_LEVELS     = 8'h14;
	localparam logic [7:0] REG_JOG_FREQ   = 8'h18;
	localparam logic [7:0] REG_MAX_FREQ   = 8'h1C;
	localparam logic [7:0] REG_START_FREQ = 8'h20;
	localparam logic [7:0] REG_UD_STEP    = 8'h24;
	localparam logic [7:0] REG_REF_FREQ   = 8'h28;
	localparam logic [7:0] REG_LIMITS     = 8'h2C;
	localparam logic [7:0] REG_FUNC       = 8'h30;
	localparam logic [7:0] REG_MOTOR_CUR  = 8'h34;
	localparam logic [7:0] REG_STATUS     = 8'h38;
	localparam logic [7:0] REG_SAVED      = 8'h3C;
	// CTRL field positions
	localparam int unsigned CTRL_STOP_MODE  = 0;
	localparam int unsigned CTRL_INERTIA    = 2;
	localparam int unsigned CTRL_METHOD     = 4;
	localparam int unsigned CTRL_UD_SAVE    = 8;
	localparam int unsigned CTRL_UD_MODE    = 9;
	localparam int unsigned CTRL_LIMIT_EN   = 11;

	typedef enum logic [2:0] {
		ST_IDLE, ST_START_BRAKE, ST_RUN, ST_DECEL, ST_WAIT, ST_BRAKE, ST_HOLD_BRAKE
	} dbj_state_t;

	typedef struct packed {
		logic [15:0] freq;
		logic        reverse;
		logic        outputOn;
		logic [7:0]  brakeLevel;
		logic        brakeOn;
		logic [1:0]  brakeGain;
	} dbj_drive_t;
endpackage : dbj_pkg

// ---- hdl/dbj_sequencer.sv ----
// Output frequency and DC brake sequencer with jog and up-down setting.
// Assumes APB master on clk_sys and raw terminal pins from switches.
`timescale 1ns/1ns
module dbj_sequencer
	import dbj_pkg::*;
#(
	parameter int unsigned TICK_CYCLES     = TICK_CYC,
	parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
	parameter int unsigned RAMP_CYCLES     = RAMP_CYC_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        forward_run_cmd,
	input  wire logic        reverseRunCmd,
	input  wire logic [7:0]  inputPins,
	output dbj_drive_t       driveCmd
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [11:0] ctrl_r;
	logic [15:0] brake_start_freq_r, brake_wait_time_r, brake_duration_r;
	logic [15:0] start_brake_duration_r, jog_freq_r, max_freq_r, start_freq_r;
	logic [15:0] updown_step_freq_r, refFreq_r, upperLim_r, lowerLim_r;
	logic [15:0] motor_rated_current_r, updown_saved_freq_r;
	logic [7:0]  brake_level_r, start_brake_level_r;
	logic [39:0] funcSel_r;
	dbj_state_t  state_r;
	logic [15:0] freq_r, target_r, timer_r;

	function automatic logic [15:0] clampFreq(input logic [15:0] f, input logic [15:0] lo,
		input logic [15:0] hi);
		clampFreq = (f < lo) ? lo : ((f > hi) ? hi : f);
	endfunction : clampFreq

	function automatic logic [7:0] clampLvl(input logic [7:0] v);
		clampLvl = (v > LEVEL_MAX) ? LEVEL_MAX : v;
	endfunction : clampLvl

	// ----------------------------------------------------------------
	// APB access
	// ----------------------------------------------------------------
	// Read data loads in the setup cycle so it stands at the access edge
	wire logic        apbWr = psel & penable & pwrite;
	wire logic        apbRd = psel & ~penable & ~pwrite;
	logic             mapped;
	always_comb begin
		mapped = (paddr[1:0] == 2'h0) && (paddr <= REG_SAVED);
	end
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_r                 <= 12'h000;
			brake_start_freq_r     <= BRAKE_START_FREQ_RST;
			brake_wait_time_r      <= BRAKE_WAIT_TIME_RST;
			brake_duration_r       <= BRAKE_DURATION_RST;
			start_brake_duration_r <= START_BRAKE_DUR_RST;
			brake_level_r          <= BRAKE_LEVEL_RST;
			start_brake_level_r    <= START_BRAKE_LVL_RST;
			jog_freq_r             <= JOG_FREQ_RST;
			max_freq_r             <= MAX_FREQ_RST;
			start_freq_r           <= START_FREQ_RST;
			updown_step_freq_r     <= 16'h0000;
			refFreq_r              <= 16'h0000;
			upperLim_r             <= MAX_FREQ_RST;
			lowerLim_r             <= START_FREQ_RST;
			funcSel_r              <= 40'h0000000000;
			motor_rated_current_r  <= MOTOR_CURRENT_RST;
		end else if (apbWr) begin
			case (paddr)
				REG_CTRL:       ctrl_r <= pwdata[11:0];
				REG_BRAKE_FREQ: brake_start_freq_r <= pwdata[15:0];
				REG_BRAKE_WAIT: brake_wait_time_r <= pwdata[15:0];
				REG_BRAKE_DUR:  brake_duration_r <= pwdata[15:0];
				REG_START_DUR:  start_brake_duration_r <= pwdata[15:0];
				REG_LEVELS: begin
					brake_level_r       <= clampLvl(pwdata[7:0]);
					start_brake_level_r <= clampLvl(pwdata[15:8]);
				end
				REG_JOG_FREQ:   jog_freq_r <= pwdata[15:0];
				REG_MAX_FREQ:   max_freq_r <= pwdata[15:0];
				REG_START_FREQ: start_freq_r <= pwdata[15:0];
				REG_UD_STEP:    updown_step_freq_r <= pwdata[15:0];
				REG_REF_FREQ:   refFreq_r <= pwdata[15:0];
				REG_LIMITS: begin
					lowerLim_r <= pwdata[15:0];
					upperLim_r <= pwdata[31:16];
				end
				REG_FUNC:       funcSel_r[31:0] <= pwdata;
				REG_MOTOR_CUR:  motor_rated_current_r <= clampFreq(pwdata[15:0],
					MOTOR_CURRENT_MIN, MOTOR_CURRENT_MAX);
				REG_STATUS:     funcSel_r[39:32] <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Input conditioning
	// ----------------------------------------------------------------
	logic [9:0] pinSync1_r, pinSync2_r, pinDeb_r, pinDebDly_r;
	logic [9:0][21:0] debCnt_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pinSync1_r  <= 10'h000;
			pinSync2_r  <= 10'h000;
			pinDeb_r    <= 10'h000;
			pinDebDly_r <= 10'h000;
			debCnt_r    <= '0;
		end else begin
			pinSync1_r  <= {reverseRunCmd, forward_run_cmd, inputPins};
			pinSync2_r  <= pinSync1_r;
			pinDebDly_r <= pinDeb_r;
			for (int i = 0; i < 10; i++) begin
				if (pinSync2_r[i] == pinDeb_r[i]) begin
					debCnt_r[i] <= 22'h000000;
				end else if (debCnt_r[i] >= 22'(DEBOUNCE_CYCLES - 1)) begin
					debCnt_r[i] <= 22'h000000;
					pinDeb_r[i] <= pinSync2_r[i];
				end else begin
					debCnt_r[i] <= debCnt_r[i] + 22'h000001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Terminal function decode
	// ----------------------------------------------------------------
	logic fJog, fBrake, fUp, fDown, fClr, fJogF, fJogR, defUp, defDown, upRise, dnRise;
	logic upFall, dnFall;
	always_comb begin
		logic [4:0] fn;
		fn = 5'h00;
		{fJog, fBrake, fUp, fDown, fClr, fJogF, fJogR, defUp, defDown} = '0;
		{upRise, dnRise, upFall, dnFall} = '0;
		for (int i = 0; i < 8; i++) begin
			fn = funcSel_r[i*5 +: 5];
			fJog   |= (fn == FN_JOG) & pinDeb_r[i];
			fBrake |= (fn == FN_DC_BRAKE) & pinDeb_r[i];
			fUp    |= (fn == FN_UP) & pinDeb_r[i];
			fDown  |= (fn == FN_DOWN) & pinDeb_r[i];
			fClr   |= (fn == FN_UD_CLEAR) & pinDeb_r[i];
			fJogF  |= (fn == FN_JOG_FWD) & pinDeb_r[i];
			fJogR  |= (fn == FN_JOG_REV) & pinDeb_r[i];
			defUp   |= (fn == FN_UP);
			defDown |= (fn == FN_DOWN);
			upRise |= (fn == FN_UP) & pinDeb_r[i] & ~pinDebDly_r[i];
			dnRise |= (fn == FN_DOWN) & pinDeb_r[i] & ~pinDebDly_r[i];
			upFall |= (fn == FN_UP) & ~pinDeb_r[i] & pinDebDly_r[i];
			dnFall |= (fn == FN_DOWN) & ~pinDeb_r[i] & pinDebDly_r[i];
		end
	end

	// ----------------------------------------------------------------
	// Timebase and command selection
	// ----------------------------------------------------------------
	logic [27:0] tickCnt_r;
	logic [15:0] rampCnt_r;
	logic        tick, rampEn;
	assign tick   = (tickCnt_r == 28'(TICK_CYCLES - 1));
	assign rampEn = (rampCnt_r == 16'(RAMP_CYCLES - 1));
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tickCnt_r <= 28'h0000000;
			rampCnt_r <= 16'h0000;
		end else begin
			tickCnt_r <= tick ? 28'h0000000 : tickCnt_r + 28'h0000001;
			rampCnt_r <= rampEn ? 16'h0000 : rampCnt_r + 16'h0001;
		end
	end

	wire logic [1:0] stopMode  = ctrl_r[CTRL_STOP_MODE +: 2];
	wire logic [1:0] inertia   = ctrl_r[CTRL_INERTIA +: 2];
	wire logic [3:0] method    = ctrl_r[CTRL_METHOD +: 4];
	wire logic       udSave    = ctrl_r[CTRL_UD_SAVE];
	wire logic [1:0] udMode    = ctrl_r[CTRL_UD_MODE +: 2];
	wire logic       limEn     = ctrl_r[CTRL_LIMIT_EN];
	wire logic       udActive  = (method == FREQ_METHOD_UPDOWN);
	wire logic       jogAny    = fJog | fJogF | fJogR;
	wire logic       runCmd    = pinDeb_r[8] | pinDeb_r[9] | fJogF | fJogR;
	wire logic [15:0] hiLim    = limEn ? upperLim_r : max_freq_r;
	wire logic [15:0] loLim    = limEn ? lowerLim_r : start_freq_r;
	wire logic [15:0] jogEff   = clampFreq(jog_freq_r, start_freq_r, max_freq_r);
	wire logic       stopBrakeOn  = (brake_level_r != 8'h00) && (brake_duration_r != 16'h0000);
	wire logic       startBrakeOn = (start_brake_level_r != 8'h00)
		&& (start_brake_duration_r != 16'h0000);

	// ----------------------------------------------------------------
	// Up-down setpoint
	// ----------------------------------------------------------------
	logic [15:0] udFreq_r;
	logic [5:0]  holdCnt_r;
	logic        stepBusy_r;
	wire logic   contMode = (udMode == 2'h0) || ((udMode == 2'h2) && (holdCnt_r >= HOLD_TICKS));
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			udFreq_r   <= 16'h0000;
			holdCnt_r  <= 6'h00;
			stepBusy_r <= 1'b0;
		end else begin
			if (!(fUp | fDown)) begin
				holdCnt_r <= 6'h00;
			end else if (tick && holdCnt_r < HOLD_TICKS) begin
				holdCnt_r <= holdCnt_r + 6'h01;
			end
			if (stepBusy_r && (freq_r == udFreq_r || jogAny
				|| state_r != ST_RUN)) begin
				stepBusy_r <= 1'b0;
			end
			if (!udActive) begin
				udFreq_r <= updown_saved_freq_r;
			end else if (contMode) begin
				if (fUp && rampEn && udFreq_r < hiLim) begin
					udFreq_r <= udFreq_r + RAMP_STEP;
				end else if (fDown && rampEn && udFreq_r > loLim) begin
					udFreq_r <= udFreq_r - RAMP_STEP;
				end
			end else if ((upRise | dnRise) && !stepBusy_r) begin
				stepBusy_r <= 1'b1;
				if (upRise) begin
					udFreq_r <= clampFreq(16'(udFreq_r + updown_step_freq_r), loLim, hiLim);
				end else begin
					udFreq_r <= (udFreq_r > 16'(loLim + updown_step_freq_r))
						? 16'(udFreq_r - updown_step_freq_r) : loLim;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Saved frequency
	// ----------------------------------------------------------------
	wire logic stopping = (state_r == ST_RUN) && !runCmd;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			updown_saved_freq_r <= 16'h0000;
		end else if (udActive && udSave) begin
			if (fClr && !(fUp | fDown)) begin
				updown_saved_freq_r <= 16'h0000;
			end else if (udMode == 2'h1 && (upFall | dnFall)) begin
				updown_saved_freq_r <= udFreq_r;
			end else if (udMode != 2'h1 && stopping) begin
				updown_saved_freq_r <= freq_r;
			end else if (udMode == 2'h1 && stopping && !(defUp | defDown)) begin
				updown_saved_freq_r <= updown_saved_freq_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		if (jogAny) begin
			target_r = jogEff;
		end else if (udActive) begin
			target_r = udFreq_r;
		end else begin
			target_r = clampFreq(refFreq_r, loLim, hiLim);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			freq_r  <= 16'h0000;
			timer_r <= 16'h0000;
		end else begin
			if (tick && timer_r != 16'h0000) begin
				timer_r <= timer_r - 16'h0001;
			end
			case (state_r)
				ST_IDLE: begin
					freq_r <= 16'h0000;
					if (runCmd) begin
						if (startBrakeOn) begin
							state_r <= ST_START_BRAKE;
							timer_r <= start_brake_duration_r;
						end else begin
							state_r <= ST_RUN;
						end
					end else if (fBrake) begin
						state_r <= ST_HOLD_BRAKE;
					end
				end
				ST_START_BRAKE: if (timer_r == 16'h0000) state_r <= ST_RUN;
				ST_RUN: begin
					if (!runCmd) begin
						state_r <= (stopMode == STOP_MODE_BRAKE && stopBrakeOn)
							? ST_DECEL : ST_IDLE;
					end else if (rampEn && freq_r < target_r) begin
						freq_r <= freq_r + RAMP_STEP;
					end else if (rampEn && freq_r > target_r) begin
						freq_r <= freq_r - RAMP_STEP;
					end
				end
				ST_DECEL: begin
					if (freq_r <= brake_start_freq_r) begin
						state_r <= ST_WAIT;
						timer_r <= brake_wait_time_r;
					end else if (rampEn) begin
						freq_r <= freq_r - RAMP_STEP;
					end
				end
				ST_WAIT: if (timer_r == 16'h0000) begin
					state_r <= ST_BRAKE;
					timer_r <= brake_duration_r;
				end
				ST_BRAKE: if (timer_r == 16'h0000) state_r <= ST_IDLE;
				ST_HOLD_BRAKE: if (!fBrake || runCmd) state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Output command register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			driveCmd <= '0;
		end else begin
			driveCmd.freq      <= (state_r == ST_RUN || state_r == ST_DECEL) ? freq_r : 16'h0000;
			driveCmd.reverse   <= fJogR | (pinDeb_r[9] & ~pinDeb_r[8]);
			driveCmd.outputOn  <= state_r != ST_IDLE && state_r != ST_WAIT;
			driveCmd.brakeOn   <= state_r == ST_BRAKE || state_r == ST_START_BRAKE
				|| state_r == ST_HOLD_BRAKE;
			driveCmd.brakeLevel <= (state_r == ST_BRAKE) ? brake_level_r
				: start_brake_level_r;
			driveCmd.brakeGain <= inertia;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (apbRd) begin
			case (paddr)
				REG_CTRL:       prdata <= {20'h00000, ctrl_r};
				REG_BRAKE_FREQ: prdata <= {16'h0000, brake_start_freq_r};
				REG_BRAKE_WAIT: prdata <= {16'h0000, brake_wait_time_r};
				REG_BRAKE_DUR:  prdata <= {16'h0000, brake_duration_r};
				REG_START_DUR:  prdata <= {16'h0000, start_brake_duration_r};
				REG_LEVELS:     prdata <= {16'h0000, start_brake_level_r, brake_level_r};
				REG_JOG_FREQ:   prdata <= {16'h0000, jog_freq_r};
				REG_MAX_FREQ:   prdata <= {16'h0000, max_freq_r};
				REG_START_FREQ: prdata <= {16'h0000, start_freq_r};
				REG_UD_STEP:    prdata <= {16'h0000, updown_step_freq_r};
				REG_REF_FREQ:   prdata <= {16'h0000, refFreq_r};
				REG_LIMITS:     prdata <= {upperLim_r, lowerLim_r};
				REG_FUNC:       prdata <= funcSel_r[31:0];
				REG_MOTOR_CUR:  prdata <= {16'h0000, motor_rated_current_r};
				REG_STATUS:     prdata <= {freq_r, 5'h00, state_r, funcSel_r[39:32]};
				REG_SAVED:      prdata <= {16'h0000, updown_saved_freq_r};
				default:        prdata <= 32'h00000000;
			endcase
		end
	end
endmodule : dbj_sequencer

// ---- tb/dbj_sequencer_bench.sv ----
// Self-checking bench for the brake, jog and up-down sequencer.
// Assumes short tick, debounce and ramp counts and a chattering switch model.
`timescale 1ns/1ns
module dbj_sequencer_bench
	import dbj_pkg::*;
;
	logic        clk_sys;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [9:0]  want;
	logic [9:0]  pins;
	logic [31:0] q;
	logic        e;
	dbj_drive_t  driveCmd;
	int          mismatches;
	int          comparisons;
	int          n;
	int          k;
	logic [72:0] rows [7];

	dbj_sequencer #(.TICK_CYCLES(10), .DEBOUNCE_CYCLES(2), .RAMP_CYCLES(2)) i_dbj_sequencer (
		.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.forward_run_cmd(pins[8]), .reverseRunCmd(pins[9]), .inputPins(pins[7:0]),
		.driveCmd(driveCmd));
	dbj_switches i_dbj_switches (.clk_sys(clk_sys), .want(want), .pins(pins));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// ----------------
	// Tasks
	// ----------------
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	task automatic tmo(input logic [31:0] got, input logic [31:0] exp);
		mismatches++;
		$display("[FAIL] t=%0t timeout got=%0h exp=%0h", $time, got, exp);
		results();
	endtask : tmo
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic [7:0] a, input logic [31:0] d, input logic w);
		int c;
		c = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			c++;
		end while (pready !== 1'b1 && c < 50);
		if (c >= 50)
			tmo(32'(pready), 32'h1);
		e = pslverr;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 32'h0, 1'b0);
		chk(q, exp);
	endtask : rdChk
	task automatic waitOn(input int sel, input logic [15:0] f);
		int c;
		c = 0;
		while (!(sel == 0 ? driveCmd.brakeOn === 1'b1 :
			sel == 1 ? driveCmd.brakeOn === 1'b0 :
			sel == 3 ? driveCmd.outputOn === 1'b0 : driveCmd.freq === f)) begin
			@(posedge clk_sys);
			if (++c > 30000)
				tmo(32'(driveCmd.freq), 32'(f));
		end
	endtask : waitOn
	// ----------------
	// Sequence
	// ----------------
	initial begin
		rows[0] = {REG_BRAKE_FREQ, 32'h1F4, 32'h1F4, 1'b0};
		rows[1] = {REG_BRAKE_DUR, 32'hA, 32'hA, 1'b0};
		rows[2] = {REG_LEVELS, 32'hFFFF, 32'hC8C8, 1'b0};
		rows[3] = {REG_MOTOR_CUR, 32'h1, 32'h5, 1'b0};
		rows[4] = {REG_MOTOR_CUR, 32'hFFFF, 32'h1F4, 1'b0};
		rows[5] = {8'h40, 32'h1234, 32'h0, 1'b1};
		rows[6] = {8'h05, 32'h1234, 32'h0, 1'b1};
		{psel, penable, pwrite, paddr, pwdata, want} = '0;
		{mismatches, comparisons} = '0;
		rst = 1'b1;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		foreach (rows[i]) begin
			apb(rows[i][72:65], rows[i][64:33], 1'b1);
			chk(32'(e), 32'(rows[i][0]));
			rdChk(rows[i][72:65], rows[i][32:1]);
		end
		rdChk(REG_BRAKE_WAIT, 32'(BRAKE_WAIT_TIME_RST));
		rdChk(REG_START_DUR, 32'(START_BRAKE_DUR_RST));
		rdChk(REG_JOG_FREQ, 32'(JOG_FREQ_RST));
		rdChk(REG_START_FREQ, 32'(START_FREQ_RST));
		$display("done: registers");
		apb(REG_LEVELS, 32'h4032, 1'b1);
		apb(REG_START_DUR, 32'h2, 1'b1);
		apb(REG_FUNC, 32'h35983D64, 1'b1);
		apb(REG_STATUS, 32'h0, 1'b1);
		apb(REG_UD_STEP, 32'h64, 1'b1);
		apb(REG_CTRL, 32'h389, 1'b1);
		want <= 10'h101;
		waitOn(0, 16'h0);
		chk(32'(driveCmd.brakeLevel), 32'h40);
		chk(32'(driveCmd.freq), 32'h0);
		waitOn(1, 16'h0);
		waitOn(2, JOG_FREQ_RST);
		want <= 10'h000;
		waitOn(2, BRAKE_START_FREQ_RST);
		waitOn(3, 16'h0);
		chk(32'(driveCmd.brakeOn), 32'h0);
		waitOn(0, 16'h0);
		chk(32'(driveCmd.brakeLevel), 32'h32);
		chk(32'(driveCmd.brakeGain), 32'h2);
		chk(32'(driveCmd.freq <= BRAKE_START_FREQ_RST), 32'h1);
		n = 0;
		while (driveCmd.brakeOn === 1'b1 && n < 1000) begin
			@(posedge clk_sys);
			n++;
		end
		chk(32'(n >= 90 && n <= 102), 32'h1);
		$display("done: start brake, jog, stop brake");
		apb(REG_LEVELS, 32'h4000, 1'b1);
		apb(REG_START_DUR, 32'h0, 1'b1);
		want <= 10'h020;
		waitOn(2, JOG_FREQ_RST);
		chk(32'(driveCmd.reverse), 32'h0);
		want <= 10'h000;
		k = 0;
		repeat (1500) begin
			@(posedge clk_sys);
			k += (driveCmd.brakeOn === 1'b1);
		end
		chk(k, 0);
		waitOn(2, 16'h0);
		want <= 10'h002;
		waitOn(0, 16'h0);
		chk(32'(driveCmd.brakeLevel), 32'h40);
		want <= 10'h000;
		waitOn(1, 16'h0);
		$display("done: skip, jog forward, brake input");
		want <= 10'h100;
		repeat (20) @(posedge clk_sys);
		for (int s = 1; s <= 2; s++) begin
			want <= 10'h104;
			waitOn(2, 16'(s * 100));
			want <= 10'h100;
			repeat (20) @(posedge clk_sys);
		end
		want <= 10'h101;
		waitOn(2, JOG_FREQ_RST);
		want <= 10'h100;
		waitOn(2, 16'hC8);
		want <= 10'h000;
		waitOn(2, 16'h0);
		rdChk(REG_SAVED, 32'hC8);
		want <= 10'h010;
		repeat (20) @(posedge clk_sys);
		want <= 10'h000;
		rdChk(REG_SAVED, 32'h0);
		$display("done: up-down steps, save, clear");
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk(32'(driveCmd), 32'h0);
		rdChk(REG_LEVELS, 32'({START_BRAKE_LVL_RST, BRAKE_LEVEL_RST}));
		rdChk(REG_MOTOR_CUR, 32'(MOTOR_CURRENT_RST));
		rdChk(REG_SAVED, 32'h0);
		$display("done: reset");
		results();
	end
endmodule : dbj_sequencer_bench

// ---- tb/dbj_sequencer_chk.sv ----
// Port checker for the brake, jog and up-down sequencer.
// Assumes it is bound to dbj_sequencer, one clock domain.
`timescale 1ns/1ns
module dbj_sequencer_chk
	import dbj_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire dbj_drive_t  driveCmd
);
	logic [15:0] maxFreq_r;
	logic [1:0]  inertia_r;
	wire         wrAcc = psel && penable && pwrite;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ----------------
	// Shadow settings
	// ----------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			maxFreq_r <= MAX_FREQ_RST;
		else if (wrAcc && paddr == REG_MAX_FREQ)
			maxFreq_r <= pwdata[15:0];
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			inertia_r <= 2'h0;
		else if (wrAcc && paddr == REG_CTRL)
			inertia_r <= pwdata[CTRL_INERTIA +: 2];
	end
	a_ready_high: assert property (pready) else $error("pready low");
	a_misalign_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access without error");
	a_mapped_ok: assert property (psel && penable && paddr[1:0] == 2'h0 && paddr <= REG_SAVED
		|-> !pslverr) else $error("mapped access flagged");
	a_err_read_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_level_cap: assert property (driveCmd.brakeLevel <= LEVEL_MAX)
		else $error("brake level above cap");
	a_brake_level_set: assert property (driveCmd.brakeOn |-> driveCmd.brakeLevel != 8'h00)
		else $error("braking at zero level");
	a_brake_gain_map: assert property (driveCmd.brakeOn
		|-> driveCmd.brakeGain == $past(inertia_r))
		else $error("brake gain differs from inertia");
	a_freq_cap: assert property (driveCmd.freq <= maxFreq_r)
		else $error("frequency above maximum");
endmodule : dbj_sequencer_chk

bind dbj_sequencer dbj_sequencer_chk i_dbj_sequencer_chk (.clk_sys(clk_sys), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .driveCmd(driveCmd));

// ---- tb/dbj_switches.sv ----
// Chattering switch model for run pins and multi-function terminals.
// Assumes bits 7:0 terminals, bit 8 forward run, bit 9 reverse run.
`timescale 1ns/1ns
module dbj_switches (
	input  wire logic       clk_sys,
	input  wire logic [9:0] want,
	output logic      [9:0] pins
);
	logic [9:0] new_r = 10'h000;
	logic [9:0] old_r = 10'h000;
	logic [2:0] cnt_r = 3'h0;
	// Contacts chatter between old and new level before settling
	always @(posedge clk_sys) begin
		if (want != new_r) begin
			old_r <= new_r;
			new_r <= want;
			cnt_r <= 3'h5;
		end else if (cnt_r != 3'h0)
			cnt_r <= cnt_r - 3'h1;
	end
	assign pins = cnt_r[0] ? old_r : new_r;
endmodule : dbj_switches
